// >>> hw/qiop_pkg.sv
// Package with register map, reset values and types of the quad and octal port block.
package qiop_pkg;

    // Register indices; the byte address on the bus is four times the index.
    localparam logic [15:0] QUAD_PORT_OUTPUT_DATA_IDX = 16'hFFDD;
    localparam logic [15:0] INPUT_PORT_PIN_LEVELS_IDX = 16'hFFDE;
    localparam logic [15:0] QUAD_PORT_DIRECTION_IDX   = 16'hFFED;

    // Values after reset and fixed read patterns.
    localparam logic [7:0]  QUAD_DATA_RESET     = 8'hF0;
    localparam logic [7:0]  QUAD_DIR_RESET      = 8'hF0;
    localparam logic [7:0]  QUAD_UNUSED_ONES    = 8'hF0;
    localparam logic [7:0]  DIR_READ_VALUE      = 8'hFF;
    localparam logic [3:0]  SEG_SELECT_GPIO     = 4'h0;
    localparam logic [3:0]  ADC_CH_FIRST        = 4'h4;
    localparam logic [3:0]  ADC_CH_LAST         = 4'hB;
    localparam logic [31:0] APB_READ_DEFAULT    = 32'h0000_0000;

    // Drive state of the four shared pins.
    typedef struct packed {
        logic [3:0] level;
        logic [3:0] oe_n;
    } qiop_drive_t;

    // Bus answer computed in the setup cycle.
    typedef struct packed {
        logic [31:0] rdata;
        logic        err;
    } qiop_answer_t;

    // Byte address of a register index.
    function automatic logic [31:0] qiop_addr(input logic [15:0] idx);
        qiop_addr = {14'h0000, idx, 2'b00};
    endfunction : qiop_addr

endpackage : qiop_pkg

// >>> hw/qiop_port.sv
// Quad bidirectional port and octal input-only port with an APB register slave.
//
// Functional notes
// - Data register bits 3:0, upper bits read one.
// - Output pin reads back latched data bit.
// - Input pin reads current pin level.
// - Data register resets to F0.
// - Direction one is output, zero input.
// - Port settings act only in GPIO function.
// - Direction register resets to F0, inputs.
// - Direction register write-only, reads all ones.
// - Segment select zero GPIO, else LCD common.
// - Hi-Z reset/standby, hold in sleep.
// - Second port: eight input-only pins.
// - Input port read-only, returns pin levels.
// - Analog-selected input pin reads zero.
// - Data and direction registers at fixed addresses.
`timescale 1ns/10ps
`default_nettype none

module qiop_port
    import qiop_pkg::*;
(
    input  wire logic        CLK,
    input  wire logic        RESET,
    input  wire logic        PSEL,
    input  wire logic        PENABLE,
    input  wire logic        PWRITE,
    input  wire logic [31:0] PADDR,
    input  wire logic [31:0] PWDATA,
    output logic      [31:0] PRDATA,
    output logic             PREADY,
    output logic             PSLVERR,
    input  wire logic [3:0]  QUAD_PIN_IN,
    output logic      [3:0]  QUAD_PIN_OUT,
    output logic      [3:0]  QUAD_PIN_OE_N,
    input  wire logic [7:0]  INPUT_PIN_IN,
    input  wire logic [3:0]  SEGMENT_SELECT_FIELD,
    input  wire logic [3:0]  LCD_COMMON,
    input  wire logic [3:0]  ADC_CHANNEL_SELECT,
    input  wire logic        SLEEP,
    input  wire logic        STANDBY
);

    logic [3:0]   quad_meta_q;
    logic [3:0]   quad_sync_q;
    logic [7:0]   in_meta_q;
    logic [7:0]   in_sync_q;
    logic [3:0]   data_q;
    logic [3:0]   data_d;
    logic [3:0]   dir_q;
    logic [3:0]   dir_d;
    qiop_drive_t  drive_q;
    qiop_drive_t  drive_d;
    qiop_answer_t ans_q;
    qiop_answer_t ans_d;

    // Pins arrive from outside the clock domain; only the second stage is read.
    always_ff @(posedge CLK or posedge RESET) begin
        if (RESET) begin
            quad_meta_q <= 4'h0;
            quad_sync_q <= 4'h0;
            in_meta_q   <= 8'h00;
            in_sync_q   <= 8'h00;
        end else begin
            quad_meta_q <= QUAD_PIN_IN;
            quad_sync_q <= quad_meta_q;
            in_meta_q   <= INPUT_PIN_IN;
            in_sync_q   <= in_meta_q;
        end
    end

    // Address decode, one wire per register.
    wire setup_phase = PSEL & ~PENABLE;
    wire access_phase = PSEL & PENABLE;
    wire hit_data = (PADDR == qiop_addr(QUAD_PORT_OUTPUT_DATA_IDX));
    wire hit_dir = (PADDR == qiop_addr(QUAD_PORT_DIRECTION_IDX));
    wire hit_in = (PADDR == qiop_addr(INPUT_PORT_PIN_LEVELS_IDX));
    wire wr_data = access_phase & PWRITE & hit_data;
    wire wr_dir = access_phase & PWRITE & hit_dir;

    // Writes to the read-only input port and unmapped addresses are refused with an error; direction register reads are not.
    wire bad_access = ~(hit_data | hit_dir | (hit_in & ~PWRITE));

    // Readback mixes latched data for outputs and live pin levels for inputs.
    wire [3:0] quad_read = (dir_q & data_q) | (~dir_q & quad_sync_q);

    // Analog channels map onto input pins in code order; a claimed pin reads zero.
    wire       adc_claims = (ADC_CHANNEL_SELECT >= ADC_CH_FIRST) && (ADC_CHANNEL_SELECT <= ADC_CH_LAST);
    wire [2:0] adc_pin = 3'(ADC_CHANNEL_SELECT - ADC_CH_FIRST);
    wire [7:0] adc_mask = adc_claims ? (8'h01 << adc_pin) : 8'h00;
    wire [7:0] in_read = in_sync_q & ~adc_mask;

    wire [7:0] read_byte = hit_data ? (QUAD_UNUSED_ONES | {4'h0, quad_read}) :
                           hit_dir  ? DIR_READ_VALUE :
                           hit_in   ? in_read : 8'h00;

    assign ans_d.rdata = setup_phase ? ((bad_access | PWRITE) ? APB_READ_DEFAULT : {24'h00_0000, read_byte})
                                     : ans_q.rdata;
    assign ans_d.err   = setup_phase ? bad_access : ans_q.err;
    assign data_d      = wr_data ? PWDATA[3:0] : data_q;
    assign dir_d       = wr_dir ? PWDATA[3:0] : dir_q;

    // Pin function: general port when the segment field is zero, LCD common otherwise.
    wire       gpio_mode = (SEGMENT_SELECT_FIELD == SEG_SELECT_GPIO);
    wire [3:0] run_level = gpio_mode ? data_q : LCD_COMMON;
    wire [3:0] run_oe_n = gpio_mode ? ~dir_q : 4'h0;

    // Sleep freezes the last drive; standby floats the pins like reset does.
    assign drive_d.level = SLEEP ? drive_q.level : run_level;
    assign drive_d.oe_n  = STANDBY ? 4'hF : (SLEEP ? drive_q.oe_n : run_oe_n);

    always_ff @(posedge CLK or posedge RESET) begin
        if (RESET) begin
            data_q  <= QUAD_DATA_RESET[3:0];
            dir_q   <= QUAD_DIR_RESET[3:0];
            drive_q <= {4'h0, 4'hF};
            ans_q   <= {APB_READ_DEFAULT, 1'b0};
        end else begin
            data_q  <= data_d;
            dir_q   <= dir_d;
            drive_q <= drive_d;
            ans_q   <= ans_d;
        end
    end

    // Zero wait states: the answer computed in setup stands through the access phase.
    assign PREADY        = access_phase;
    assign PRDATA        = ans_q.rdata;
    assign PSLVERR       = access_phase & ans_q.err;
    assign QUAD_PIN_OUT  = drive_q.level;
    assign QUAD_PIN_OE_N = drive_q.oe_n;

    default clocking cb @(posedge CLK); endclocking
    default disable iff (RESET);

    a_data_write_lands: assert property (
        wr_data |=> data_q == $past(PWDATA[3:0])
    ) else $error("data register did not take the written value");

    a_dir_reads_ones: assert property (
        setup_phase && hit_dir && !PWRITE |=> PRDATA == 32'h0000_00FF
    ) else $error("direction register did not read all ones");

    a_output_readback: assert property (
        setup_phase && hit_data && !PWRITE && dir_q == 4'hF |=> PRDATA[7:0] == {4'hF, $past(data_q)}
    ) else $error("output pins did not read latched data");

    a_input_readback: assert property (
        setup_phase && hit_data && !PWRITE && dir_q == 4'h0 |=> PRDATA[7:0] == {4'hF, $past(quad_sync_q)}
    ) else $error("input pins did not read pin levels");

    a_gpio_drive: assert property (
        !SLEEP && !STANDBY && gpio_mode |=> QUAD_PIN_OE_N == ~$past(dir_q) && QUAD_PIN_OUT == $past(data_q)
    ) else $error("general port drive does not follow direction and data");

    a_lcd_drive: assert property (
        !SLEEP && !STANDBY && !gpio_mode |=> QUAD_PIN_OE_N == 4'h0 && QUAD_PIN_OUT == $past(LCD_COMMON)
    ) else $error("LCD common not driven when segment field is nonzero");

    a_standby_float: assert property (
        STANDBY |=> QUAD_PIN_OE_N == 4'hF
    ) else $error("pins not floating in standby");

    a_sleep_holds: assert property (
        SLEEP && !STANDBY |=> $stable(QUAD_PIN_OUT) && $stable(QUAD_PIN_OE_N)
    ) else $error("pins changed during sleep");

    a_adc_pin_zero: assert property (
        setup_phase && hit_in && !PWRITE && adc_claims |=> PRDATA[$past(adc_pin)] == 1'b0
    ) else $error("analog selected input pin did not read zero");

    a_input_ro_error: assert property (
        setup_phase && hit_in && PWRITE ##1 access_phase |-> PSLVERR
    ) else $error("write to read-only input port not refused");

    a_unused_bits_ones: assert property (
        setup_phase && hit_data && !PWRITE |=> PRDATA[7:4] == 4'hF
    ) else $error("unused data register bits did not read one");

    a_upper_read_zero: assert property (
        setup_phase && !PWRITE && !bad_access |=> PRDATA[31:8] == 24'h00_0000
    ) else $error("read data above the byte not zero");

    a_write_rdata_zero: assert property (
        setup_phase && PWRITE |=> PRDATA == 32'h0000_0000
    ) else $error("write answer carried nonzero read data");

    a_error_rdata_zero: assert property (
        setup_phase && bad_access |=> PRDATA == 32'h0000_0000
    ) else $error("refused access carried nonzero read data");

    a_ready_in_access: assert property (
        access_phase |-> PREADY
    ) else $error("ready missing in access phase");

    a_no_ready_idle: assert property (
        !access_phase |-> !PREADY && !PSLVERR
    ) else $error("ready or error outside access phase");

    a_dir_write_lands: assert property (
        wr_dir |=> dir_q == $past(PWDATA[3:0])
    ) else $error("direction register did not take the written value");

    a_data_holds: assert property (
        !wr_data |=> $stable(data_q)
    ) else $error("data register changed without a write");

    a_dir_holds: assert property (
        !wr_dir |=> $stable(dir_q)
    ) else $error("direction register changed without a write");

    a_input_levels: assert property (
        setup_phase && hit_in && !PWRITE && !adc_claims |=> PRDATA[7:0] == $past(in_sync_q)
    ) else $error("input port did not read pin levels");

    a_no_claim_mask: assert property (
        !adc_claims |-> adc_mask == 8'h00
    ) else $error("input pin masked without an analog claim");

    a_dir_read_ok: assert property (
        setup_phase && hit_dir && !PWRITE ##1 access_phase |-> !PSLVERR
    ) else $error("direction register read refused");

    a_unmapped_error: assert property (
        setup_phase && !(hit_data || hit_dir || hit_in) ##1 access_phase |-> PSLVERR
    ) else $error("unmapped address not refused");

    a_standby_wins: assert property (
        STANDBY && SLEEP |=> QUAD_PIN_OE_N == 4'hF
    ) else $error("sleep kept pins driven in standby");

    a_gpio_inputs_float: assert property (
        !SLEEP && !STANDBY && gpio_mode && dir_q == 4'h0 |=> QUAD_PIN_OE_N == 4'hF
    ) else $error("input pins were driven");

endmodule : qiop_port

`default_nettype wire

// >>> dv/qiop_pins.sv
// Board model of the four shared pins.
`timescale 1ns/10ps
`default_nettype none
module qiop_pins (
    input  wire logic [3:0] dev_out,
    input  wire logic [3:0] dev_oe_n,
    input  wire logic [3:0] ext_lvl,
    output logic      [3:0] pin_lvl
);
    // The board drives every pin the port releases, so a released wire never keeps a stale level.
    assign pin_lvl = (~dev_oe_n & dev_out) | (dev_oe_n & ext_lvl);
endmodule : qiop_pins
`default_nettype wire

// >>> dv/qiop_port_tb.sv
// Self-checking bench of the quad and octal port block.
`timescale 1ns/10ps
`default_nettype none
module qiop_port_tb
    import qiop_pkg::*;
;
    logic        clk, rst, psel, pen, pwr, slp, stb, err, pready, pslverr;
    logic [31:0] paddr, pwdata, prdata, rd;
    logic [3:0]  qin, qout, qoe_n, seg, lcd, adc, ext, eo;
    logic [7:0]  bin, e;
    int          bad_count, total_checks;
    // Row: segment field, direction, data, board level, expected read.
    logic [23:0] rows [6] = '{24'h0F_5AF5, 24'h00_5AFA, 24'h03_1CFD, 24'h0C_83FB, 24'h10_95F6, 24'h8F_30F3};
    qiop_port u_qiop_port (.CLK(clk), .RESET(rst), .PSEL(psel), .PENABLE(pen), .PWRITE(pwr),
        .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready), .PSLVERR(pslverr),
        .QUAD_PIN_IN(qin), .QUAD_PIN_OUT(qout), .QUAD_PIN_OE_N(qoe_n), .INPUT_PIN_IN(bin),
        .SEGMENT_SELECT_FIELD(seg), .LCD_COMMON(lcd), .ADC_CHANNEL_SELECT(adc), .SLEEP(slp),
        .STANDBY(stb));
    qiop_pins u_qiop_pins (.dev_out(qout), .dev_oe_n(qoe_n), .ext_lvl(ext), .pin_lvl(qin));
    initial begin
        clk = 0;
        forever #12.5 clk = ~clk;
    end
    task automatic chk(input string nm, input logic [31:0] x, input logic [31:0] g);
        total_checks++;
        if (g !== x) begin
            bad_count++;
            $display("wrong value %s exp %h got %h", nm, x, g);
        end
    endtask : chk
    task automatic give_verdict;
        $display("checks %0d errors %0d", total_checks, bad_count);
        if (bad_count == 0 && total_checks > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask : give_verdict
    // Zero wait states are expected, yet the master still waits for the answer under a bound.
    task automatic apb(input logic w, input logic [15:0] idx, input logic [7:0] d);
        int n;
        n = 0;
        @(posedge clk);
        psel <= 1;
        pwr <= w;
        paddr <= {14'h0000, idx, 2'b00};
        pwdata <= {24'h00_0000, d};
        @(posedge clk);
        pen <= 1;
        do @(posedge clk); while (pready !== 1'b1 && ++n < 50);
        if (pready !== 1'b1) begin
            bad_count++;
            give_verdict();
        end
        rd = prdata;
        err = pslverr;
        psel <= 0;
        pen <= 0;
    endtask : apb
    initial begin
        {rst, psel, pen, pwr, slp, stb} = 6'b10_0000;
        {paddr, pwdata} = 64'h0;
        {seg, adc, lcd, ext, bin} = 24'h00_6A00;
        {bad_count, total_checks} = 0;
        repeat (6) @(posedge clk);
        chk("reset oe_n", 4'hF, qoe_n);
        rst <= 0;
        repeat (3) @(posedge clk);
        apb(0, QUAD_PORT_DIRECTION_IDX, 0);
        chk("dir read", 8'hFF, rd);
        apb(1, QUAD_PORT_DIRECTION_IDX, 8'h0F);
        apb(0, QUAD_PORT_OUTPUT_DATA_IDX, 0);
        chk("data reset", 8'hF0, rd);
        foreach (rows[i]) begin
            apb(1, QUAD_PORT_DIRECTION_IDX, rows[i][19:16]);
            apb(1, QUAD_PORT_OUTPUT_DATA_IDX, rows[i][15:12]);
            seg <= rows[i][23:20];
            ext <= rows[i][11:8];
            repeat (4) @(posedge clk);
            apb(0, QUAD_PORT_OUTPUT_DATA_IDX, 0);
            eo = (seg != 0) ? 4'h0 : ~rows[i][19:16];
            chk("data read", rows[i][7:0], rd);
            chk("oe_n", eo, qoe_n);
            chk("drive", (seg != 0 ? lcd : rows[i][15:12]) & ~eo, qout & ~qoe_n);
        end
        for (int c = 0; c < 16; c++) begin
            adc <= c[3:0];
            bin <= {c[3:0], ~c[3:0]};
            repeat (4) @(posedge clk);
            apb(0, INPUT_PORT_PIN_LEVELS_IDX, 0);
            e = {c[3:0], ~c[3:0]};
            if (c >= 4 && c <= 11) e[c - 4] = 1'b0;
            chk("input read", e, rd);
        end
        apb(1, INPUT_PORT_PIN_LEVELS_IDX, 8'h00);
        chk("ro write err", 1, err);
        apb(0, 16'hFFDF, 0);
        chk("unmapped err", 1, err);
        seg <= 0;
        repeat (3) @(posedge clk);
        slp <= 1;
        apb(1, QUAD_PORT_OUTPUT_DATA_IDX, 8'h0C);
        repeat (3) @(posedge clk);
        chk("sleep hold", 4'h3, qout);
        stb <= 1;
        repeat (3) @(posedge clk);
        chk("standby oe_n", 4'hF, qoe_n);
        give_verdict();
    end
endmodule : qiop_port_tb
`default_nettype wire
